//--- hdl/spl_stack_guard.sv
// Our own choices: the register addresses and the Avalon-MM register port.
module spl_stack_guard
	import spl_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic resetn_i,
	// Avalon-MM slave
	input wire logic [SPL_AW-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Stack operations from the core
	input wire logic push_i,
	input wire logic pop_i,
	input wire logic [1:0] push_kind_i,
	input wire logic [15:0] push_data_i,
	input wire logic [22:0] pc_i,
	input wire logic [7:0] status_low_byte_i,
	// Other effective addresses formed with the stack pointer
	input wire logic sp_ea_valid_i,
	input wire logic [15:0] sp_ea_i,
	// Stack memory access
	output logic [15:0] stk_addr_o,
	output logic [15:0] stk_wdata_o,
	output logic stk_we_o,
	output logic stk_re_o,
	output logic busy_o,
	output logic [15:0] sp_o,
	// Exception logic
	output logic trap_req_o,
	input wire logic trap_ack_i,
	// Interrupt
	output logic irq_o
);

	// =====================================================================
	// State
	// =====================================================================
	typedef struct packed {
		spl_fsm_t fsm;
		spl_push_kind_t kind;
		logic [15:0] stack_pointer_reg;
		logic [15:0] stack_limit_reg;
		logic [SPL_EVT_W-1:0] status;
		logic [SPL_EVT_W-1:0] mask;
		logic trap;
		logic irq;
		logic [15:0] addr;
		logic [15:0] wdata;
		logic we;
		logic re;
		logic waitreq;
		logic [31:0] rdata;
	} spl_state_t;

	localparam spl_state_t SPL_ST_RESET = '{
		fsm: SPL_FS_IDLE,
		kind: SPL_PK_DATA,
		stack_pointer_reg: SPL_SP_RESET,
		stack_limit_reg: SPL_LIMIT_SIM,
		status: SPL_STATUS_RESET,
		mask: SPL_MASK_RESET,
		trap: 1'b0,
		irq: 1'b0,
		addr: 16'h0000,
		wdata: 16'h0000,
		we: 1'b0,
		re: 1'b0,
		waitreq: 1'b1,
		rdata: 32'h0000_0000
	};

	spl_state_t st;
	spl_state_t next_st;

	// =====================================================================
	// Helpers: bound checkers and push formatter
	// =====================================================================
	spl_stk_if op_if ();
	spl_stk_if ea_if ();

	logic start_push;
	logic start_pop;
	logic op_check;
	logic [15:0] pop_sp;

	always_comb begin
		start_push = (st.fsm == SPL_FS_IDLE) && push_i;
		start_pop = (st.fsm == SPL_FS_IDLE) && !push_i && pop_i;
		op_check = start_push || start_pop || (st.fsm == SPL_FS_PCHI);
		pop_sp = st.stack_pointer_reg - SPL_WORD_STEP;
	end

	always_comb begin
		op_if.ea = start_pop ? pop_sp : st.stack_pointer_reg;
		op_if.limit = st.stack_limit_reg;
		op_if.kind = (st.fsm == SPL_FS_PCHI) ? st.kind : spl_push_kind_t'(push_kind_i);
		op_if.hi_half = (st.fsm == SPL_FS_PCHI);
		op_if.data = push_data_i;
		op_if.pc = pc_i;
		op_if.status_low_byte = status_low_byte_i;
		ea_if.ea = sp_ea_i;
		ea_if.limit = st.stack_limit_reg;
		ea_if.kind = SPL_PK_DATA;
		ea_if.hi_half = 1'b0;
		ea_if.data = 16'h0000;
		ea_if.pc = 23'h000000;
		ea_if.status_low_byte = 8'h00;
	end

	spl_bound_chk u_op_chk (
		.chk(op_if.chk)
	);

	spl_bound_chk u_ea_chk (
		.chk(ea_if.chk)
	);

	spl_push_fmt u_fmt (
		.fmt(op_if.fmt)
	);

	// =====================================================================
	// Next state
	// =====================================================================
	logic bus_req;
	logic bus_commit;
	logic [15:0] wmask;
	logic [SPL_EVT_W-1:0] evt;
	logic [SPL_EVT_W-1:0] status_clr;

	always_comb begin
		next_st = st;
		next_st.we = 1'b0;
		next_st.re = 1'b0;
		bus_req = avs_read_i || avs_write_i;
		bus_commit = bus_req && !st.waitreq;
		wmask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
		evt = '0;
		status_clr = '0;

		// Bus: one wait cycle, then commit at the edge seen with waitrequest low
		if (bus_req && st.waitreq) begin
			next_st.waitreq = 1'b0;
			next_st.rdata = 32'h0000_0000;
			unique case (avs_address_i)
				SPL_OFF_SP: next_st.rdata[15:0] = spl_align(st.stack_pointer_reg);
				SPL_OFF_LIMIT: next_st.rdata[15:0] = spl_align(st.stack_limit_reg);
				SPL_OFF_STATUS: next_st.rdata[SPL_EVT_W-1:0] = st.status;
				SPL_OFF_MASK: next_st.rdata[SPL_EVT_W-1:0] = st.mask;
				default: next_st.rdata = 32'h0000_0000;
			endcase
		end else if (bus_commit) begin
			next_st.waitreq = 1'b1;
			if (avs_write_i) begin
				unique case (avs_address_i)
					SPL_OFF_SP: begin
						next_st.stack_pointer_reg = spl_align((st.stack_pointer_reg & ~wmask)
							| (avs_writedata_i[15:0] & wmask));
					end
					SPL_OFF_LIMIT: begin
						next_st.stack_limit_reg = spl_align((st.stack_limit_reg & ~wmask)
							| (avs_writedata_i[15:0] & wmask));
					end
					SPL_OFF_MASK: begin
						if (avs_byteenable_i[0]) begin
							next_st.mask = avs_writedata_i[SPL_EVT_W-1:0];
						end
					end
					default: begin
					end
				endcase
			end else if (avs_address_i == SPL_OFF_STATUS) begin
				// Clear only the bits the read returned; a later event stays pending
				status_clr = st.rdata[SPL_EVT_W-1:0];
			end
		end

		// Stack operations
		unique case (st.fsm)
			SPL_FS_IDLE: begin
				if (start_push) begin
					next_st.addr = spl_align(st.stack_pointer_reg);
					next_st.wdata = op_if.word;
					next_st.we = 1'b1;
					next_st.stack_pointer_reg = spl_align(st.stack_pointer_reg + SPL_WORD_STEP);
					next_st.kind = spl_push_kind_t'(push_kind_i);
					if (spl_push_kind_t'(push_kind_i) != SPL_PK_DATA) begin
						next_st.fsm = SPL_FS_PCHI;
					end
				end else if (start_pop) begin
					next_st.stack_pointer_reg = spl_align(pop_sp);
					next_st.addr = spl_align(pop_sp);
					next_st.re = 1'b1;
				end
			end
			SPL_FS_PCHI: begin
				next_st.addr = spl_align(st.stack_pointer_reg);
				next_st.wdata = op_if.word;
				next_st.we = 1'b1;
				next_st.stack_pointer_reg = spl_align(st.stack_pointer_reg + SPL_WORD_STEP);
				next_st.fsm = SPL_FS_IDLE;
			end
		endcase

		// Bound errors: pushes check overflow, every stack access checks underflow
		if (op_check) begin
			evt[SPL_BIT_OVF] = op_if.ovf && !start_pop;
			evt[SPL_BIT_UNF] = op_if.unf;
		end
		if (sp_ea_valid_i) begin
			evt[SPL_BIT_OVF] = evt[SPL_BIT_OVF] | ea_if.ovf;
			evt[SPL_BIT_UNF] = evt[SPL_BIT_UNF] | ea_if.unf;
		end

		// Sticky status: a new event wins over a clearing read
		next_st.status = (st.status & ~status_clr) | evt;
		next_st.trap = (st.trap && !trap_ack_i) || (|evt);
		next_st.irq = |(next_st.status & next_st.mask);
	end

	// =====================================================================
	// Registers
	// =====================================================================
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			st <= SPL_ST_RESET;
			st.stack_limit_reg <= next_st.stack_limit_reg;
		end else begin
			st <= next_st;
		end
	end

	// =====================================================================
	// Outputs
	// =====================================================================
	always_comb begin
		avs_readdata_o = st.rdata;
		avs_waitrequest_o = st.waitreq;
		stk_addr_o = st.addr;
		stk_wdata_o = st.wdata;
		stk_we_o = st.we;
		stk_re_o = st.re;
		busy_o = (st.fsm == SPL_FS_PCHI);
		sp_o = st.stack_pointer_reg;
		trap_req_o = st.trap;
		irq_o = st.irq;
	end

endmodule : spl_stack_guard

//--- common/spl_pkg.sv
package spl_pkg;

	// =====================================================================
	// Data path widths and step
	// =====================================================================
	localparam int SPL_DW = 16;
	localparam int SPL_PC_W = 23;
	localparam int SPL_SRL_W = 8;
	localparam logic [15:0] SPL_WORD_STEP = 16'h0002;

	// =====================================================================
	// Stack bounds and reset values
	// =====================================================================
	localparam logic [15:0] SPL_SP_FLOOR = 16'h0800;
	localparam logic [15:0] SPL_SP_RESET = 16'h0800;
	localparam logic [1:0] SPL_STATUS_RESET = 2'h0;
	localparam logic [1:0] SPL_MASK_RESET = 2'h0;
	localparam logic [15:0] SPL_LIMIT_SIM = 16'h0000;

	// =====================================================================
	// Register map (byte addresses on the Avalon-MM slave)
	// =====================================================================
	localparam int SPL_AW = 4;
	localparam logic [3:0] SPL_OFF_SP = 4'h0;
	localparam logic [3:0] SPL_OFF_LIMIT = 4'h4;
	localparam logic [3:0] SPL_OFF_STATUS = 4'h8;
	localparam logic [3:0] SPL_OFF_MASK = 4'hc;

	// =====================================================================
	// Status and mask layout
	// =====================================================================
	localparam int SPL_EVT_W = 2;
	localparam int SPL_BIT_OVF = 0;
	localparam int SPL_BIT_UNF = 1;

	// =====================================================================
	// Types
	// =====================================================================
	typedef enum logic [1:0] {
		SPL_PK_DATA = 2'h0,
		SPL_PK_CALL = 2'h1,
		SPL_PK_EXC = 2'h2
	} spl_push_kind_t;

	typedef enum logic [1:0] {
		SPL_FS_IDLE = 2'b01,
		SPL_FS_PCHI = 2'b10
	} spl_fsm_t;

	// Stack words are always even addresses
	function automatic logic [15:0] spl_align(input logic [15:0] a);
		spl_align = {a[15:1], 1'b0};
	endfunction : spl_align

endpackage : spl_pkg

//--- common/spl_stk_if.sv
interface spl_stk_if;
	import spl_pkg::*;

	// Bound check
	logic [15:0] ea;
	logic [15:0] limit;
	logic ovf;
	logic unf;
	// Push word formatting
	spl_push_kind_t kind;
	logic hi_half;
	logic [15:0] data;
	logic [22:0] pc;
	logic [7:0] status_low_byte;
	logic [15:0] word;

	modport chk (input ea, input limit, output ovf, output unf);
	modport fmt (input kind, input hi_half, input data, input pc, input status_low_byte, output word);
	modport top (
		output ea, output limit, input ovf, input unf,
		output kind, output hi_half, output data, output pc, output status_low_byte, input word
	);

endinterface : spl_stk_if

//--- hdl/spl_bound_chk.sv
module spl_bound_chk
	import spl_pkg::*;
(
	// Address and limit in, errors out
	spl_stk_if.chk chk
);

	// =====================================================================
	// Compare
	// =====================================================================
	always_comb begin
		chk.ovf = spl_align(chk.ea) > spl_align(chk.limit);
		chk.unf = spl_align(chk.ea) < SPL_SP_FLOOR;
	end

endmodule : spl_bound_chk

//--- hdl/spl_push_fmt.sv
module spl_push_fmt
	import spl_pkg::*;
(
	// Push request in, stack word out
	spl_stk_if.fmt fmt
);

	// =====================================================================
	// Word select
	// =====================================================================
	always_comb begin
		fmt.word = fmt.data;
		if (fmt.kind != SPL_PK_DATA) begin
			if (!fmt.hi_half) begin
				fmt.word = fmt.pc[15:0];
			end else if (fmt.kind == SPL_PK_EXC) begin
				fmt.word = {fmt.status_low_byte, 1'b0, fmt.pc[22:16]};
			end else begin
				fmt.word = {8'h00, 1'b0, fmt.pc[22:16]};
			end
		end
	end

endmodule : spl_push_fmt

//--- tb/spl_exc_model.sv
module spl_exc_model (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic resetn_i,
	// Trap handshake
	input wire logic trap_req_i,
	output logic trap_ack_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] wait_cnt;
	// Takes a pending stack error a few cycles after it rises
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i || !trap_req_i) begin
			wait_cnt <= 3'h0;
			trap_ack_o <= 1'h0;
		end else begin
			wait_cnt <= wait_cnt + 3'h1;
			trap_ack_o <= (wait_cnt == 3'h4);
		end
	end
endmodule : spl_exc_model

//--- tb/spl_stack_guard_properties.sv
module spl_stack_guard_properties
	import spl_pkg::*;
(
	// Clock, reset, bus
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic avs_waitrequest_o,
	// Stack side
	input wire logic push_i,
	input wire logic pop_i,
	input wire logic [1:0] push_kind_i,
	input wire logic [22:0] pc_i,
	input wire logic [7:0] status_low_byte_i,
	input wire logic sp_ea_valid_i,
	input wire logic [15:0] sp_ea_i,
	input wire logic [15:0] stk_addr_o,
	input wire logic [15:0] stk_wdata_o,
	input wire logic stk_we_o,
	input wire logic stk_re_o,
	input wire logic busy_o,
	input wire logic [15:0] sp_o,
	input wire logic trap_req_o,
	input wire logic trap_ack_i
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [22:0] pc_d;
	logic [7:0] srl_d;
	always_ff @(posedge core_clk_i) begin
		pc_d <= pc_i;
		srl_d <= status_low_byte_i;
	end
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);
	a_bus_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
		|=> !avs_waitrequest_o ##1 avs_waitrequest_o) else $error("bus answer not one cycle");
	a_push_write: assert property (
		push_i && !busy_o |=> stk_we_o && stk_addr_o == $past(sp_o))
		else $error("push not written at pointer");
	a_push_step: assert property (
		push_i && !busy_o && push_kind_i == 2'h0 |=> sp_o == $past(sp_o) + SPL_WORD_STEP)
		else $error("push step wrong");
	a_pop_read: assert property (
		pop_i && !push_i && !busy_o |=> stk_re_o && sp_o == stk_addr_o
		&& stk_addr_o == $past(sp_o) - SPL_WORD_STEP) else $error("pop wrong");
	a_sp_even: assert property (
		!sp_o[0] && !stk_addr_o[0]) else $error("odd stack address");
	a_call_high: assert property (
		push_i && !busy_o && push_kind_i == 2'h1 |=> busy_o ##1
		stk_we_o && stk_wdata_o == {9'h000, pc_d[22:16]}) else $error("call word wrong");
	a_exc_high: assert property (
		push_i && !busy_o && push_kind_i == 2'h2 |=> ##1
		stk_we_o && stk_wdata_o == {srl_d, 1'h0, pc_d[22:16]}) else $error("exc word wrong");
	a_ea_under: assert property (
		sp_ea_valid_i && sp_ea_i < SPL_SP_FLOOR |=> trap_req_o)
		else $error("underflow not trapped");
	a_trap_hold: assert property (
		trap_req_o && !trap_ack_i |=> trap_req_o)
		else $error("trap dropped early");
endmodule : spl_stack_guard_properties
bind spl_stack_guard spl_stack_guard_properties spl_stack_guard_properties_i (
	.core_clk_i(core_clk_i), .resetn_i(resetn_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o), .push_i(push_i),
	.pop_i(pop_i), .push_kind_i(push_kind_i), .pc_i(pc_i), .status_low_byte_i(status_low_byte_i),
	.sp_ea_valid_i(sp_ea_valid_i), .sp_ea_i(sp_ea_i), .stk_addr_o(stk_addr_o),
	.stk_wdata_o(stk_wdata_o), .stk_we_o(stk_we_o), .stk_re_o(stk_re_o), .busy_o(busy_o),
	.sp_o(sp_o), .trap_req_o(trap_req_o), .trap_ack_i(trap_ack_i));

//--- tb/spl_stack_guard_test.sv
module spl_stack_guard_test;
	import spl_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk_i = 1'h0, resetn_i = 1'h0, avs_read_i = 1'h0, avs_write_i = 1'h0;
	logic push_i = 1'h0, pop_i = 1'h0, sp_ea_valid_i = 1'h0, trap_ack_i;
	logic [3:0] avs_address_i = 4'h0, avs_byteenable_i = 4'h3;
	logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rd;
	logic [1:0] push_kind_i = 2'h0;
	logic [15:0] push_data_i = 16'h0, sp_ea_i = 16'h0, stk_addr_o, stk_wdata_o, sp_o;
	logic [22:0] pc_i = 23'h0;
	logic [7:0] status_low_byte_i = 8'h0;
	logic avs_waitrequest_o, stk_we_o, stk_re_o, busy_o, trap_req_o, irq_o;
	int errors = 0;
	int samples_checked = 0;
	always #50 core_clk_i = ~core_clk_i;
	spl_stack_guard spl_stack_guard_i (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.push_i(push_i), .pop_i(pop_i), .push_kind_i(push_kind_i), .push_data_i(push_data_i),
		.pc_i(pc_i), .status_low_byte_i(status_low_byte_i), .sp_ea_valid_i(sp_ea_valid_i),
		.sp_ea_i(sp_ea_i), .stk_addr_o(stk_addr_o), .stk_wdata_o(stk_wdata_o),
		.stk_we_o(stk_we_o), .stk_re_o(stk_re_o), .busy_o(busy_o), .sp_o(sp_o),
		.trap_req_o(trap_req_o), .trap_ack_i(trap_ack_i), .irq_o(irq_o));
	spl_exc_model spl_exc_model_i (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
		.trap_req_i(trap_req_o), .trap_ack_o(trap_ack_i));
	// =====
	// Tasks
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask : tick
	task automatic end_sim();
		if (errors == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic rst();
		resetn_i <= 1'h0;
		tick(20);
		resetn_i <= 1'h1;
		tick(1);
	endtask : rst
	task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
		avs_address_i <= a;
		avs_write_i <= w;
		avs_read_i <= !w;
		avs_writedata_i <= {16'h0, d};
		tick(1);
		while (avs_waitrequest_o !== 1'h0) begin
			tick(1);
		end
		rd = avs_readdata_o;
		avs_write_i <= 1'h0;
		avs_read_i <= 1'h0;
		tick(1);
	endtask : bus
	task automatic rdc(input string n, input logic [3:0] a, input logic [15:0] e);
		bus(1'h0, a, 16'h0);
		chk(n, {16'h0, e}, rd);
	endtask : rdc
	task automatic op(input logic p, input logic [1:0] k, input logic [15:0] d, a, hi, s);
		push_i <= p;
		pop_i <= !p;
		push_kind_i <= k;
		push_data_i <= d;
		tick(1);
		push_i <= 1'h0;
		pop_i <= 1'h0;
		tick(1);
		chk("stk_addr", a, stk_addr_o);
		chk("strobe", 32'h1, p ? stk_we_o : stk_re_o);
		if (p) chk("stk_wdata", d, stk_wdata_o);
		if (p && k != 2'h0) begin
			chk("busy", 32'h1, busy_o);
			tick(1);
			chk("stk_addr", a + SPL_WORD_STEP, stk_addr_o);
			chk("stk_wdata", hi, stk_wdata_o);
		end
		tick(1);
		chk("sp", s, sp_o);
	endtask : op
	task automatic ea(input logic [15:0] a, input logic e);
		sp_ea_valid_i <= 1'h1;
		sp_ea_i <= a;
		tick(1);
		sp_ea_valid_i <= 1'h0;
		tick(2);
		chk("trap", {31'h0, e}, trap_req_o);
	endtask : ea
	// =====
	// Tests
	initial begin
		rst();
		rdc("sp", SPL_OFF_SP, SPL_SP_RESET);
		rdc("status", SPL_OFF_STATUS, 16'h0);
		rdc("mask", SPL_OFF_MASK, 16'h0);
		rdc("unmapped", 4'h2, 16'h0);
		bus(1'h1, SPL_OFF_LIMIT, 16'h0a03);
		rdc("limit", SPL_OFF_LIMIT, 16'h0a02);
		rst();
		rdc("limit", SPL_OFF_LIMIT, 16'h0a02);
		bus(1'h1, SPL_OFF_SP, 16'h09fd);
		rdc("sp", SPL_OFF_SP, 16'h09fc);
		for (int i = 0; i < 4; i++) begin
			op(1'h1, 2'h0, 16'h1230 + 16'(i), 16'h09fc + 16'(2 * i), 16'h0, 16'h09fe + 16'(2 * i));
			chk("trap", 32'h0, trap_req_o);
		end
		op(1'h1, 2'h0, 16'h5a5a, 16'h0a04, 16'h0, 16'h0a06);
		chk("trap", 32'h1, trap_req_o);
		chk("irq", 32'h0, irq_o);
		rdc("status", SPL_OFF_STATUS, 16'h1);
		rdc("status", SPL_OFF_STATUS, 16'h0);
		tick(12);
		chk("trap", 32'h0, trap_req_o);
		bus(1'h1, SPL_OFF_MASK, 16'h3);
		op(1'h0, 2'h0, 16'h0, 16'h0a04, 16'h0, 16'h0a04);
		op(1'h1, 2'h0, 16'h0f0f, 16'h0a04, 16'h0, 16'h0a06);
		tick(1);
		chk("irq", 32'h1, irq_o);
		rdc("status", SPL_OFF_STATUS, 16'h1);
		tick(1);
		chk("irq", 32'h0, irq_o);
		tick(12);
		bus(1'h1, SPL_OFF_SP, 16'h0802);
		op(1'h0, 2'h0, 16'h0, 16'h0800, 16'h0, 16'h0800);
		chk("trap", 32'h0, trap_req_o);
		op(1'h0, 2'h0, 16'h0, 16'h07fe, 16'h0, 16'h07fe);
		chk("trap", 32'h1, trap_req_o);
		rdc("status", SPL_OFF_STATUS, 16'h2);
		tick(12);
		bus(1'h1, SPL_OFF_SP, 16'h0900);
		ea(16'h0900, 1'h0);
		ea(16'h0a04, 1'h1);
		rdc("status", SPL_OFF_STATUS, 16'h1);
		tick(12);
		ea(16'h07fe, 1'h1);
		rdc("status", SPL_OFF_STATUS, 16'h2);
		tick(12);
		pc_i <= 23'h7f1234;
		status_low_byte_i <= 8'ha5;
		op(1'h1, 2'h1, 16'h1234, 16'h0900, 16'h007f, 16'h0904);
		op(1'h1, 2'h2, 16'h1234, 16'h0904, 16'ha57f, 16'h0908);
		end_sim();
	end
	initial begin
		tick(3000);
		errors++;
		end_sim();
	end
endmodule : spl_stack_guard_test
